// ---- src/keyfob_cfg.svh ----
`ifndef KEYFOB_CFG_SVH
`define KEYFOB_CFG_SVH

// -----------------------------------------------------------------
// Clock and timing.
// -----------------------------------------------------------------
`define CLK_MHZ     125
`define SETTLE_US   2000
`define SETTLE_CYC  (`SETTLE_US * `CLK_MHZ)
`define CHIP_US     250
`define CHIP_CYC    (`CHIP_US * `CLK_MHZ)
`define TMR_W       18

// -----------------------------------------------------------------
// Key scan.
// -----------------------------------------------------------------
`define SCAN_DWELL  4'h6
`define DWELL_W     4
// Cycles the column filter needs, all rows driven, before wake is armed.
`define ARM_WAIT    5

// -----------------------------------------------------------------
// Frame and supply check.
// -----------------------------------------------------------------
`define SYNC_W      8
`define SYNC_WORD   8'h96
`define ADC_W       8
// Converter code of the lowest supply the transmitter accepts.
`define SUPPLY_MIN  8'h6b

`endif

// ---- src/keyfob_pkg.sv ----
package keyfob_pkg;

    typedef enum logic [2:0] {
        ST_PDOWN  = 3'h0,
        ST_SLEEP  = 3'h1,
        ST_SCAN   = 3'h2,
        ST_CHECK  = 3'h3,
        ST_SETTLE = 3'h4,
        ST_SEND   = 3'h5
    } seq_state_e;

    typedef struct packed {
        logic power;
        logic ask;
        logic fsk;
    } tx_lines_s;

    typedef struct packed {
        logic fsk_mode;
        logic manchester;
    } tx_mode_s;

endpackage

// ---- src/key_scan.sv ----
`timescale 1ns/100ps
`include "keyfob_cfg.svh"

module key_scan #(
    parameter int NROW = 2,
    parameter int NCOL = 2
) (
    input  wire logic                 clock,     // System clock.
    input  wire logic                 nrst,      // Async reset, low.
    input  wire logic                 run,       // Sweep the matrix.
    input  wire logic                 arm,       // Snapshot for wake.
    input  wire logic [NCOL-1:0]      col_sense, // Column pins.
    output logic      [NROW-1:0]      row_drive, // Row pins, high = on.
    output logic      [NROW*NCOL-1:0] code,      // Pressed-key map.
    output logic                      done,      // Sweep finished.
    output logic                      wake       // Columns changed.
);

    if (NROW < 1 || NCOL < 1 || NROW > 8) begin : g_size_check
        $error("key_scan: unsupported matrix size");
    end

    localparam int RW = (NROW > 1) ? $clog2(NROW) : 1;

    logic [NCOL-1:0]      s1_q, s2_q, s3_q, col_q, col_d, snap_q, snap_d;
    logic [RW-1:0]        row_q, row_d;
    logic [`DWELL_W-1:0]  dw_q, dw_d;
    logic [NROW*NCOL-1:0] map_q, map_d, code_q, code_d;
    logic                 done_q, done_d;

    // -------------------------------------------------------------
    // Sweep: each row is driven for a dwell, then its columns land
    // in the map, so every key combination yields its own code.
    // -------------------------------------------------------------
    always_comb begin
        col_d  = (s2_q == s3_q) ? s3_q : col_q;
        snap_d = arm ? col_q : snap_q;
        row_d  = row_q;
        dw_d   = dw_q;
        map_d  = map_q;
        code_d = code_q;
        done_d = 1'b0;
        if (!run) begin
            row_d = '0;
            dw_d  = '0;
            map_d = '0;
        end else if (dw_q != `SCAN_DWELL) begin
            dw_d = dw_q + 1'b1;
        end else begin
            dw_d = '0;
            map_d[int'(row_q)*NCOL +: NCOL] = col_q;
            if (int'(row_q) == NROW - 1) begin
                row_d  = '0;
                code_d = map_d;
                map_d  = '0;
                done_d = 1'b1;
            end else begin
                row_d = row_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            col_q  <= '0;
            snap_q <= '0;
            row_q  <= '0;
            dw_q   <= '0;
            map_q  <= '0;
            code_q <= '0;
            done_q <= 1'b0;
        end else begin
            s1_q   <= col_sense;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            col_q  <= col_d;
            snap_q <= snap_d;
            row_q  <= row_d;
            dw_q   <= dw_d;
            map_q  <= map_d;
            code_q <= code_d;
            done_q <= done_d;
        end
    end

    // While idle all rows stay on so any key shows on a column.
    always_comb begin
        row_drive = '1;
        if (run) begin
            row_drive = '0;
            row_drive[row_q] = 1'b1;
        end
    end

    assign code = code_q;
    assign done = done_q;
    assign wake = (col_q != snap_q);

endmodule

// ---- src/keyfob_tx_sequencer.sv ----
`timescale 1ns/100ps
`include "keyfob_cfg.svh"

module keyfob_tx_sequencer #(
    parameter int NROW       = 2,
    parameter int NCOL       = 2,
    parameter int SETTLE_CYC = `SETTLE_CYC,
    parameter int CHIP_CYC   = `CHIP_CYC
) (
    input  wire logic                 clock,              // 125 MHz.
    input  wire logic                 nrst,               // Async, low.
    input  wire logic [NCOL-1:0]      col_sense,          // Key columns.
    output logic      [NROW-1:0]      row_drive,          // Key rows.
    input  wire keyfob_pkg::tx_mode_s mode,               // Coding, keying.
    output logic                      adc_start,          // Convert pulse.
    input  wire logic                 adc_done,           // Result valid.
    input  wire logic [`ADC_W-1:0]    adc_value,          // Supply code.
    output logic                      tx_power_line,      // Tx enable.
    output logic                      amplitude_key_line, // PA keying.
    output logic                      frequency_key_line, // FSK keying.
    output logic                      sleeping,           // Low power.
    output logic                      low_supply          // Supply error.
);

    localparam int KW = NROW * NCOL;
    localparam int FW = `SYNC_W + KW;
    localparam int BW = $clog2(FW);

    if (SETTLE_CYC < 1 || SETTLE_CYC > 2 ** `TMR_W ||
        CHIP_CYC < 1 || CHIP_CYC > 2 ** `TMR_W) begin : g_count_check
        $error("keyfob_tx_sequencer: counts do not fit the timer");
    end

    // -------------------------------------------------------------
    // Key scanner.
    // -------------------------------------------------------------
    keyfob_pkg::seq_state_e state_q, state_d;
    logic                   scan_done, wake, arm;
    logic [KW-1:0]          key_code;

    key_scan #(
        .NROW (NROW),
        .NCOL (NCOL)
    ) u_scan (
        .clock     (clock),
        .nrst      (nrst),
        .run       (state_q == keyfob_pkg::ST_SCAN),
        .arm       (arm),
        .col_sense (col_sense),
        .row_drive (row_drive),
        .code      (key_code),
        .done      (scan_done),
        .wake      (wake)
    );

    // -------------------------------------------------------------
    // Sequencer.
    // -------------------------------------------------------------
    keyfob_pkg::tx_lines_s  lines_q, lines_d;
    keyfob_pkg::tx_mode_s   mode_q, mode_d;
    logic [`TMR_W-1:0]      tmr_q, tmr_d;
    logic [FW-1:0]          frame_q, frame_d;
    logic [BW-1:0]          bit_q, bit_d;
    logic                   half_q, half_d;
    logic                   low_q, low_d;
    logic                   start_q, start_d;
    logic                   supply_ok, chip;

    assign supply_ok = (adc_value >= `SUPPLY_MIN);

    function automatic logic chip_of(input logic b, input logic h,
                                     input logic man);
        chip_of = man ? (h ? ~b : b) : b;
    endfunction

    always_comb begin
        state_d = state_q;
        mode_d  = mode_q;
        tmr_d   = tmr_q;
        frame_d = frame_q;
        bit_d   = bit_q;
        half_d  = half_q;
        low_d   = low_q;
        start_d = 1'b0;
        arm     = 1'b0;
        case (state_q)
            keyfob_pkg::ST_PDOWN: begin
                // A snapshot taken before the filtered columns show all
                // rows would see a stale row and wake at once.
                if (tmr_q != '0) begin
                    tmr_d = tmr_q - 1'b1;
                end else if (lines_q == '0) begin
                    arm     = 1'b1;
                    state_d = keyfob_pkg::ST_SLEEP;
                end
            end
            keyfob_pkg::ST_SLEEP: begin
                if (wake)
                    state_d = keyfob_pkg::ST_SCAN;
            end
            keyfob_pkg::ST_SCAN: begin
                if (scan_done) begin
                    if (key_code != '0) begin
                        state_d = keyfob_pkg::ST_CHECK;
                        start_d = 1'b1;
                    end else begin
                        state_d = keyfob_pkg::ST_PDOWN;
                        tmr_d   = `TMR_W'(`ARM_WAIT);
                    end
                end
            end
            keyfob_pkg::ST_CHECK: begin
                if (adc_done) begin
                    low_d = ~supply_ok;
                    if (supply_ok) begin
                        state_d = keyfob_pkg::ST_SETTLE;
                        tmr_d   = `TMR_W'(SETTLE_CYC - 1);
                        frame_d = {`SYNC_WORD, key_code};
                        mode_d  = mode;
                    end else begin
                        state_d = keyfob_pkg::ST_PDOWN;
                        tmr_d   = `TMR_W'(`ARM_WAIT);
                    end
                end
            end
            keyfob_pkg::ST_SETTLE: begin
                if (tmr_q != '0) begin
                    tmr_d = tmr_q - 1'b1;
                end else begin
                    state_d = keyfob_pkg::ST_SEND;
                    tmr_d   = `TMR_W'(CHIP_CYC - 1);
                    bit_d   = '0;
                    half_d  = 1'b0;
                end
            end
            keyfob_pkg::ST_SEND: begin
                if (tmr_q != '0) begin
                    tmr_d = tmr_q - 1'b1;
                end else begin
                    tmr_d = `TMR_W'(CHIP_CYC - 1);
                    if (mode_q.manchester && !half_q) begin
                        half_d = 1'b1;
                    end else begin
                        half_d  = 1'b0;
                        frame_d = frame_q << 1;
                        bit_d   = bit_q + 1'b1;
                        if (int'(bit_q) == FW - 1)
                            state_d = keyfob_pkg::ST_SCAN;
                    end
                end
            end
            default: state_d = keyfob_pkg::ST_PDOWN;
        endcase

        // Keying follows the next state so line and state agree.
        chip    = chip_of(frame_d[FW-1], half_d, mode_q.manchester);
        lines_d = '0;
        if (state_d == keyfob_pkg::ST_SETTLE) begin
            lines_d.power = 1'b1;
            lines_d.fsk   = 1'b1;
        end else if (state_d == keyfob_pkg::ST_SEND) begin
            lines_d.power = 1'b1;
            lines_d.ask   = mode_q.fsk_mode ? 1'b1 : chip;
            lines_d.fsk   = mode_q.fsk_mode ? chip : 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= keyfob_pkg::ST_PDOWN;
            lines_q <= '0;
            mode_q  <= '0;
            tmr_q   <= '0;
            frame_q <= '0;
            bit_q   <= '0;
            half_q  <= 1'b0;
            low_q   <= 1'b0;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            lines_q <= lines_d;
            mode_q  <= mode_d;
            tmr_q   <= tmr_d;
            frame_q <= frame_d;
            bit_q   <= bit_d;
            half_q  <= half_d;
            low_q   <= low_d;
            start_q <= start_d;
        end
    end

    assign adc_start          = start_q;
    assign tx_power_line      = lines_q.power;
    assign amplitude_key_line = lines_q.ask;
    assign frequency_key_line = lines_q.fsk;
    assign sleeping           = (state_q == keyfob_pkg::ST_SLEEP);
    assign low_supply         = low_q;

    // -------------------------------------------------------------
    // Assertions.
    // -------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_idle_lines_low: assert property (
        sleeping |-> lines_q == '0)
        else $error("transmitter lines not low while asleep");
    a_sleep_after_low: assert property (
        $rose(sleeping) |-> $past(state_q == keyfob_pkg::ST_PDOWN
            && lines_q == '0))
        else $error("sleep entered before lines were low");
    a_wake_armed: assert property (
        $rose(sleeping) |-> $past(arm))
        else $error("sleep entered without arming wake");
    a_wake_restart: assert property (
        sleeping && wake |=> state_q == keyfob_pkg::ST_SCAN ##1 !sleeping)
        else $error("key press did not wake controller");
    a_supply_gate: assert property (
        $rose(tx_power_line) |-> $past(state_q == keyfob_pkg::ST_CHECK
            && adc_done && supply_ok))
        else $error("transmitter powered without supply check");
    a_low_skip: assert property (
        state_q == keyfob_pkg::ST_CHECK && adc_done && !supply_ok
        |=> state_q == keyfob_pkg::ST_PDOWN && low_q && !tx_power_line)
        else $error("low supply did not skip transmission");
    a_settle_pa_off: assert property (
        state_q == keyfob_pkg::ST_SETTLE |->
            tx_power_line && frequency_key_line && !amplitude_key_line)
        else $error("amplifier on during settling");
    a_settle_hold: assert property (
        state_q == keyfob_pkg::ST_SETTLE && tmr_q != '0
        |=> state_q == keyfob_pkg::ST_SETTLE)
        else $error("data started before settling expired");
    a_ask_keying: assert property (
        state_q == keyfob_pkg::ST_SEND && !mode_q.fsk_mode |->
            frequency_key_line && amplitude_key_line == frame_q[FW-1]
            ^ (mode_q.manchester & half_q))
        else $error("amplitude keying line wrong");
    a_fsk_keying: assert property (
        state_q == keyfob_pkg::ST_SEND && mode_q.fsk_mode |->
            amplitude_key_line && frequency_key_line == frame_q[FW-1]
            ^ (mode_q.manchester & half_q))
        else $error("frequency keying line wrong");
    a_nrz_one_chip: assert property (
        state_q == keyfob_pkg::ST_SEND && !mode_q.manchester |-> !half_q)
        else $error("NRZ symbol split in two");
    a_manch_pair: assert property (
        state_q == keyfob_pkg::ST_SEND && mode_q.manchester && !half_q
        && tmr_q == '0 |=> half_q && $stable(frame_q))
        else $error("Manchester bit lacks second chip");

    c_wake: cover property (sleeping && wake ##1
        state_q == keyfob_pkg::ST_SCAN);
    c_low_supply: cover property ($rose(low_q));
    c_manch_frame: cover property (state_q == keyfob_pkg::ST_SEND &&
        mode_q.manchester ##1 state_q == keyfob_pkg::ST_SCAN);
    c_fsk_send: cover property (state_q == keyfob_pkg::ST_SEND &&
        mode_q.fsk_mode);

endmodule

// ---- test/rf_tx_model.sv ----
`timescale 1ns/100ps

// ---------------------------------------------------------------
// Transmitter model: checks keying order and samples every chip.
// ---------------------------------------------------------------
module rf_tx_model #(
    parameter int SETTLE = 20,
    parameter int CHIP   = 4
) (
    input  wire logic clock,     // System clock.
    input  wire logic nrst,      // Async reset, low.
    input  wire logic power,     // Enable line.
    input  wire logic ask,       // Amplitude keying line.
    input  wire logic fsk,       // Frequency keying line.
    input  wire logic fsk_mode,  // Data rides on fsk when high.
    output logic      chip_seen, // One-cycle chip strobe.
    output logic      chip_val,  // Sampled chip.
    output int        viol       // Keying faults seen.
);
    int cnt;

    // Chips are sampled mid-period so a one-cycle skew is tolerated.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt       <= 0;
            chip_seen <= 1'b0;
            chip_val  <= 1'b0;
            viol      <= 0;
        end else begin
            chip_seen <= 1'b0;
            if (power !== 1'b1) begin
                cnt <= 0;
                if ({ask, fsk} !== 2'h0) viol <= viol + 1;
            end else begin
                cnt <= cnt + 1;
                if (cnt < SETTLE - 1) begin
                    if ({ask, fsk} !== 2'h1) viol <= viol + 1;
                end else if (cnt >= SETTLE &&
                             (cnt - SETTLE) % CHIP == CHIP / 2) begin
                    chip_seen <= 1'b1;
                    chip_val  <= fsk_mode ? fsk : ask;
                    if ((fsk_mode ? ask : fsk) !== 1'b1) begin
                        viol <= viol + 1;
                    end
                end
            end
        end
    end
endmodule

// ---- test/keyfob_tx_sequencer_test.sv ----
`timescale 1ns/100ps
`include "keyfob_cfg.svh"

module keyfob_tx_sequencer_test;
    logic                 clock;
    logic                 nrst;
    logic [1:0]           col_sense;
    logic [1:0]           row_drive;
    keyfob_pkg::tx_mode_s mode;
    logic                 adc_start;
    logic                 adc_done;
    logic [`ADC_W-1:0]    adc_value;
    logic                 tx_power_line;
    logic                 amplitude_key_line;
    logic                 frequency_key_line;
    logic                 sleeping;
    logic                 low_supply;
    logic                 chip_seen;
    logic                 chip_val;
    int                   viol;
    logic [3:0]           keys;
    logic [7:0]           supply;
    logic                 exp_q[$];
    int                   err_total = 0;
    int                   checks_done = 0;
    int                   starts = 0;
    int                   rises = 0;
    bit                   pwr_p = 0;

    keyfob_tx_sequencer #(.SETTLE_CYC(20), .CHIP_CYC(4)) dut_u (
        .clock(clock), .nrst(nrst), .col_sense(col_sense),
        .row_drive(row_drive), .mode(mode), .adc_start(adc_start),
        .adc_done(adc_done), .adc_value(adc_value),
        .tx_power_line(tx_power_line),
        .amplitude_key_line(amplitude_key_line),
        .frequency_key_line(frequency_key_line),
        .sleeping(sleeping), .low_supply(low_supply));

    rf_tx_model #(.SETTLE(20), .CHIP(4)) mdl_u (
        .clock(clock), .nrst(nrst), .power(tx_power_line),
        .ask(amplitude_key_line), .fsk(frequency_key_line),
        .fsk_mode(mode.fsk_mode), .chip_seen(chip_seen),
        .chip_val(chip_val), .viol(viol));

    // A column reads high when a pressed key sits on a driven row.
    assign col_sense[0] = |(row_drive & {keys[2], keys[0]});
    assign col_sense[1] = |(row_drive & {keys[3], keys[1]});

    initial clock = 1'b0;
    always #4 clock = ~clock;

    task automatic tick();
        @(posedge clock);
        #1;
    endtask

    task automatic check(input logic got, input logic exp, input string s);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %b exp %b", $time, s, got, exp);
        end
    endtask

    task automatic check_n(input int got, input int exp, input string s);
        checks_done++;
        if (got != exp) begin
            err_total++;
            $display("BAD %0t %s got %0d exp %0d", $time, s, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic expect_frame(input logic [3:0] k, input logic man);
        logic [`SYNC_W+3:0] f;
        f = {`SYNC_WORD, k};
        for (int i = `SYNC_W + 3; i >= 0; i--) begin
            exp_q.push_back(f[i]);
            if (man) exp_q.push_back(~f[i]);
        end
    endtask

    // ---------------------------------------------------------------
    // Supply converter stand-in and output watcher.
    // ---------------------------------------------------------------
    initial begin
        adc_done  = 1'b0;
        adc_value = 8'h00;
        forever begin
            tick();
            if (adc_start === 1'b1) begin
                repeat ($urandom_range(1, 4)) @(posedge clock);
                #1 adc_done = 1'b1;
                adc_value = supply;
                tick();
                adc_done  = 1'b0;
                adc_value = ~supply;
            end
        end
    end

    always @(posedge clock) begin
        #2;
        if (adc_start === 1'b1) starts++;
        if (tx_power_line === 1'b1 && !pwr_p) rises++;
        pwr_p = (tx_power_line === 1'b1);
        if (chip_seen === 1'b1) begin
            if (exp_q.size() == 0)
                check(1'b1, 1'b0, "unexpected chip");
            else
                check(chip_val, exp_q.pop_front(), "chip");
        end
        if (sleeping === 1'b1) begin
            check(|{tx_power_line, amplitude_key_line, frequency_key_line},
                  1'b0, "lines in sleep");
        end
    end

    // ---------------------------------------------------------------
    // One key press from sleep back to sleep.
    // ---------------------------------------------------------------
    task automatic run(input logic [3:0] k, input logic fm, input logic man,
                       input logic [7:0] sup, input bit held);
        int n;
        int s0;
        int r0;
        bit ok;
        ok = (sup >= `SUPPLY_MIN);
        s0 = starts;
        r0 = rises;
        mode.fsk_mode   = fm;
        mode.manchester = man;
        supply = sup;
        if (ok) expect_frame(k, man);
        if (ok && held) expect_frame(k, man);
        keys = k;
        for (n = 0; n < 8 && sleeping === 1'b1; n++) tick();
        check(sleeping, 1'b0, "wake");
        for (n = 0; n < 200 && (ok ? tx_power_line : low_supply) !== 1'b1;
             n++) tick();
        check(tx_power_line, ok, "power after check");
        if (held) begin
            for (n = 0; n < 300 && tx_power_line === 1'b1; n++) tick();
            for (n = 0; n < 200 && tx_power_line !== 1'b1; n++) tick();
        end
        keys = 4'h0;
        for (n = 0; n < 400 && sleeping !== 1'b1; n++) tick();
        repeat (20) tick();
        for (n = 0; n < 100 && sleeping !== 1'b1; n++) tick();
        check(sleeping, 1'b1, "back to sleep");
        check(low_supply, !ok, "supply flag");
        check_n(starts - s0, held ? 2 : 1, "supply checks");
        check_n(rises - r0, ok ? (held ? 2 : 1) : 0, "frames");
        check_n(exp_q.size(), 0, "chips left");
        check_n(viol, 0, "keying faults");
        $display("test keys %h mode %b%b done", k, fm, man);
    endtask

    initial begin
        nrst = 1'b0;
        keys = 4'h0;
        mode = '0;
        supply = 8'hff;
        void'($urandom(62212));
        repeat (20) @(posedge clock);
        #1 nrst = 1'b1;
        check(tx_power_line | amplitude_key_line | frequency_key_line,
              1'b0, "idle lines");
        for (int n = 0; n < 10 && sleeping !== 1'b1; n++) tick();
        check(sleeping, 1'b1, "sleep after reset");
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            run(4'($urandom_range(1, 15)), m[1], m[0],
                8'($urandom_range(8'h6b, 8'hff)), 1'b0);
        end
        run(4'h9, 1'b0, 1'b1, 8'h6a, 1'b0);
        run(4'hf, 1'b1, 1'b0, 8'h6b, 1'b1);
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        conclude();
    end
endmodule
